// File: logic/acd_control_map.vh
`ifndef ACD_CONTROL_MAP_VH
`define ACD_CONTROL_MAP_VH

// Device address: fixed upper bits A7..A2, A1 from the select pin, A0 = 0
`define ACD_ADDR_FIXED_HI      6'h3E
`define ACD_ADDR_WRITE_BIT     1'b0

// Bit counter value after a whole byte
`define ACD_BITS_PER_BYTE      4'h8

// Five-bit prefixes, word bits D7..D3, used when D7..D6 are zero
`define ACD_GROUP_SHORT        2'h0
`define ACD_PFX_SHUTDOWN       5'h00
`define ACD_PFX_STEREO_MODE    5'h01
`define ACD_PFX_SPATIAL        5'h02
`define ACD_PFX_SPATIAL_GAIN   5'h03
`define ACD_PFX_REGULATOR      5'h04
`define ACD_PFX_HP_GAIN        5'h05
`define ACD_PFX_SPK_STAGE      5'h06
`define ACD_PFX_EARPIECE       5'h07

// Three-bit prefixes, word bits D7..D5
`define ACD_PFX_SPK_ROUTE      3'h2
`define ACD_PFX_HP_ROUTE       3'h3
`define ACD_PFX_OUT_ENABLE     3'h4
`define ACD_PFX_MONO_GAIN      3'h5
`define ACD_PFX_LEFT_GAIN      3'h6
`define ACD_PFX_RIGHT_GAIN     3'h7

// Field positions inside the data word
`define ACD_BIT_D0             0
`define ACD_BIT_D1             1
`define ACD_BIT_D2             2
`define ACD_FIELD5_MSB         4

// Reset values
`define ACD_RST_BIT            1'b0
`define ACD_RST_FIELD2         2'h0
`define ACD_RST_FIELD3         3'h0
`define ACD_RST_FIELD5         5'h00
`define ACD_RST_BYTE           8'h00
`define ACD_RST_COUNT          4'h0
`define ACD_RST_PINS           4'hF

`endif

// File: logic/acd_control_decoder.v
`timescale 1ns/100ps
`include "acd_control_map.vh"

////////////////////////////////////////////////////////////////////////////
// Contract
// - Master owns clock; device only pulls data low
// - Answer only address with A1 from pin
// - Start condition announces an address byte
// - Address MSB first, sampled on clock rise
// - Acknowledge matched address on ninth pulse
// - Take one data word and acknowledge it
// - Reset pin low forces shutdown, clears power
// - Stay shut down until power bit written
// - Speaker routing word loads five select bits
// - Headphone routing word loads five select bits
// - Three gain words carry five-bit codes
// - Stereo mode word: mute, two input selects
// - Speaker stage: spread, right, left gain
// - Earpiece word: gain, mono, stereo select
// - Spread bit one enables spread switching
// - Input select pair picks input mode
// - Cross select swaps stereo channels to outputs
module acd_control_decoder (
    input  wire       clock_in,
    input  wire       reset_n_in,
    input  wire       scl_in,
    input  wire       sda_in,
    input  wire       addr_select_in,
    input  wire       ctrl_reset_n_in,
    output wire       sda_out,
    output reg        sda_oe_out,
    output reg        word_strobe_out,
    output wire       shutdown_out,
    output reg        power_on_bit_out,
    output reg        stereo_mute_out,
    output reg        first_pair_input_select_out,
    output reg        second_pair_input_select_out,
    output wire       differential_input_out,
    output wire [1:0] input_mode_out,
    output reg        spatial_narrow_select_out,
    output reg        spatial_on_speaker_out,
    output reg        spatial_on_headphone_out,
    output reg  [1:0] spatial_gain_out,
    output reg        regulator_high_select_out,
    output reg        turn_on_fast_out,
    output reg  [2:0] headphone_gain_out,
    output reg        spread_spectrum_enable_out,
    output reg        right_speaker_gain_select_out,
    output reg        left_speaker_gain_select_out,
    output reg        earpiece_gain_select_out,
    output reg        earpiece_mono_select_out,
    output reg        earpiece_stereo_select_out,
    output reg  [4:0] speaker_route_out,
    output reg  [4:0] headphone_route_out,
    output reg  [4:0] output_enables_out,
    output reg  [4:0] mono_gain_code_out,
    output reg  [4:0] left_gain_code_out,
    output reg  [4:0] right_gain_code_out
);

////////////////////////////////////////////////////////////////////////////
// Receiver states
localparam [2:0] ST_IDLE     = 3'h0;
localparam [2:0] ST_ADDR     = 3'h1;
localparam [2:0] ST_ADDR_ACK = 3'h2;
localparam [2:0] ST_DATA     = 3'h3;
localparam [2:0] ST_DATA_ACK = 3'h4;
localparam [2:0] ST_IGNORE   = 3'h5;

////////////////////////////////////////////////////////////////////////////
// Reset release
reg        rst_meta_n;
reg        rst_n;

always @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
        rst_meta_n <= 1'b0;
        rst_n      <= 1'b0;
    end else begin
        rst_meta_n <= 1'b1;
        rst_n      <= rst_meta_n;
    end
end

////////////////////////////////////////////////////////////////////////////
// Pin synchronisers; bit order {ctrl_reset_n, addr_select, sda, scl}
// Bus idles high, so the chain resets to one to avoid a false start.
reg  [3:0] pin_meta;
reg  [3:0] pin_sync;
reg        scl_prev;
reg        sda_prev;

always @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
        pin_meta <= `ACD_RST_PINS;
        pin_sync <= `ACD_RST_PINS;
        scl_prev <= 1'b1;
        sda_prev <= 1'b1;
    end else begin
        pin_meta <= {ctrl_reset_n_in, addr_select_in, sda_in, scl_in};
        pin_sync <= pin_meta;
        scl_prev <= pin_sync[0];
        sda_prev <= pin_sync[1];
    end
end

wire scl_s      = pin_sync[0];
wire sda_s      = pin_sync[1];
wire addr_sel_s = pin_sync[2];
wire ctrl_rst_n = pin_sync[3];

wire scl_rise   = scl_s & ~scl_prev;
wire scl_fall   = ~scl_s & scl_prev;
// Data moving while clock is high marks start or stop
wire start_seen = scl_s & scl_prev & sda_prev & ~sda_s;
wire stop_seen  = scl_s & scl_prev & ~sda_prev & sda_s;

////////////////////////////////////////////////////////////////////////////
// Serial receiver
reg  [2:0] state;
reg  [3:0] bit_count;
reg  [7:0] shift;

wire [7:0] own_addr = {`ACD_ADDR_FIXED_HI, addr_sel_s,
                       `ACD_ADDR_WRITE_BIT};
wire       addr_ok  = (shift == own_addr);
wire       byte_end = scl_fall && (bit_count == `ACD_BITS_PER_BYTE);

// Device never drives data high and never returns register contents
assign sda_out = 1'b0;

always @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
        state           <= ST_IDLE;
        bit_count       <= `ACD_RST_COUNT;
        shift           <= `ACD_RST_BYTE;
        sda_oe_out      <= 1'b0;
        word_strobe_out <= 1'b0;
    end else begin
        word_strobe_out <= 1'b0;
        if (start_seen) begin
            // Repeated start also restarts address reception
            state      <= ST_ADDR;
            bit_count  <= `ACD_RST_COUNT;
            sda_oe_out <= 1'b0;
        end else if (stop_seen) begin
            state      <= ST_IDLE;
            sda_oe_out <= 1'b0;
        end else begin
            case (state)
                ST_ADDR: begin
                    if (scl_rise) begin
                        shift     <= {shift[6:0], sda_s};
                        bit_count <= bit_count + 4'h1;
                    end else if (byte_end) begin
                        if (addr_ok) begin
                            state      <= ST_ADDR_ACK;
                            sda_oe_out <= 1'b1;
                        end else begin
                            state <= ST_IGNORE;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        state      <= ST_DATA;
                        sda_oe_out <= 1'b0;
                        bit_count  <= `ACD_RST_COUNT;
                    end
                end
                ST_DATA: begin
                    if (scl_rise) begin
                        shift     <= {shift[6:0], sda_s};
                        bit_count <= bit_count + 4'h1;
                    end else if (byte_end) begin
                        state           <= ST_DATA_ACK;
                        sda_oe_out      <= 1'b1;
                        word_strobe_out <= 1'b1;
                    end
                end
                ST_DATA_ACK: begin
                    // One word per transfer; later bytes get no answer
                    if (scl_fall) begin
                        state      <= ST_IGNORE;
                        sda_oe_out <= 1'b0;
                    end
                end
                ST_IGNORE: begin
                    sda_oe_out <= 1'b0;
                end
                ST_IDLE: begin
                    sda_oe_out <= 1'b0;
                end
                default: begin
                    state      <= ST_IDLE;
                    sda_oe_out <= 1'b0;
                end
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// Word decoder
wire [7:0] word      = shift;
wire       take      = word_strobe_out;
wire       short_grp = (word[7:6] == `ACD_GROUP_SHORT);
wire [4:0] pfx5      = word[7:3];
wire [2:0] pfx3      = word[7:5];
wire [4:0] field5    = word[`ACD_FIELD5_MSB:0];

wire wr_shutdown = take && short_grp && (pfx5 == `ACD_PFX_SHUTDOWN);
wire wr_stereo   = take && short_grp && (pfx5 == `ACD_PFX_STEREO_MODE);
wire wr_spatial  = take && short_grp && (pfx5 == `ACD_PFX_SPATIAL);
wire wr_sp_gain  = take && short_grp && (pfx5 == `ACD_PFX_SPATIAL_GAIN);
wire wr_reg      = take && short_grp && (pfx5 == `ACD_PFX_REGULATOR);
wire wr_hp_gain  = take && short_grp && (pfx5 == `ACD_PFX_HP_GAIN);
wire wr_spk_stg  = take && short_grp && (pfx5 == `ACD_PFX_SPK_STAGE);
wire wr_ear      = take && short_grp && (pfx5 == `ACD_PFX_EARPIECE);
wire wr_spk_rte  = take && (pfx3 == `ACD_PFX_SPK_ROUTE);
wire wr_hp_rte   = take && (pfx3 == `ACD_PFX_HP_ROUTE);
wire wr_enables  = take && (pfx3 == `ACD_PFX_OUT_ENABLE);
wire wr_mono     = take && (pfx3 == `ACD_PFX_MONO_GAIN);
wire wr_left     = take && (pfx3 == `ACD_PFX_LEFT_GAIN);
wire wr_right    = take && (pfx3 == `ACD_PFX_RIGHT_GAIN);

// Power bit: the reset pin wins over a write arriving in the same cycle,
// so shutdown holds for as long as the pin is low.
always @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
        power_on_bit_out <= `ACD_RST_BIT;
    end else if (!ctrl_rst_n) begin
        power_on_bit_out <= `ACD_RST_BIT;
    end else if (wr_shutdown) begin
        power_on_bit_out <= word[`ACD_BIT_D0];
    end
end

assign shutdown_out = ~power_on_bit_out;

// Each register loads only on its own prefix and holds otherwise
always @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
        stereo_mute_out               <= `ACD_RST_BIT;
        first_pair_input_select_out   <= `ACD_RST_BIT;
        second_pair_input_select_out  <= `ACD_RST_BIT;
        spatial_narrow_select_out     <= `ACD_RST_BIT;
        spatial_on_speaker_out        <= `ACD_RST_BIT;
        spatial_on_headphone_out      <= `ACD_RST_BIT;
        spatial_gain_out              <= `ACD_RST_FIELD2;
        regulator_high_select_out     <= `ACD_RST_BIT;
        turn_on_fast_out              <= `ACD_RST_BIT;
        headphone_gain_out            <= `ACD_RST_FIELD3;
        spread_spectrum_enable_out    <= `ACD_RST_BIT;
        right_speaker_gain_select_out <= `ACD_RST_BIT;
        left_speaker_gain_select_out  <= `ACD_RST_BIT;
        earpiece_gain_select_out      <= `ACD_RST_BIT;
        earpiece_mono_select_out      <= `ACD_RST_BIT;
        earpiece_stereo_select_out    <= `ACD_RST_BIT;
        speaker_route_out             <= `ACD_RST_FIELD5;
        headphone_route_out           <= `ACD_RST_FIELD5;
        output_enables_out            <= `ACD_RST_FIELD5;
        mono_gain_code_out            <= `ACD_RST_FIELD5;
        left_gain_code_out            <= `ACD_RST_FIELD5;
        right_gain_code_out           <= `ACD_RST_FIELD5;
    end else begin
        if (wr_stereo) begin
            stereo_mute_out              <= word[`ACD_BIT_D2];
            first_pair_input_select_out  <= word[`ACD_BIT_D1];
            second_pair_input_select_out <= word[`ACD_BIT_D0];
        end
        if (wr_spatial) begin
            spatial_narrow_select_out <= word[`ACD_BIT_D2];
            spatial_on_speaker_out    <= word[`ACD_BIT_D1];
            spatial_on_headphone_out  <= word[`ACD_BIT_D0];
        end
        if (wr_sp_gain) begin
            spatial_gain_out <= word[`ACD_BIT_D1:`ACD_BIT_D0];
        end
        if (wr_reg) begin
            regulator_high_select_out <= word[`ACD_BIT_D1];
            turn_on_fast_out          <= word[`ACD_BIT_D0];
        end
        if (wr_hp_gain) begin
            headphone_gain_out <= word[`ACD_BIT_D2:`ACD_BIT_D0];
        end
        if (wr_spk_stg) begin
            spread_spectrum_enable_out    <= word[`ACD_BIT_D2];
            right_speaker_gain_select_out <= word[`ACD_BIT_D1];
            left_speaker_gain_select_out  <= word[`ACD_BIT_D0];
        end
        if (wr_ear) begin
            earpiece_gain_select_out   <= word[`ACD_BIT_D2];
            earpiece_mono_select_out   <= word[`ACD_BIT_D1];
            earpiece_stereo_select_out <= word[`ACD_BIT_D0];
        end
        if (wr_spk_rte) begin
            speaker_route_out <= field5;
        end
        if (wr_hp_rte) begin
            headphone_route_out <= field5;
        end
        if (wr_enables) begin
            output_enables_out <= field5;
        end
        if (wr_mono) begin
            mono_gain_code_out <= field5;
        end
        if (wr_left) begin
            left_gain_code_out <= field5;
        end
        if (wr_right) begin
            right_gain_code_out <= field5;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// Derived mode indications for the analogue side
// Mode number equals {first pair, second pair}; zero means differential
assign input_mode_out         = {first_pair_input_select_out,
                                 second_pair_input_select_out};
assign differential_input_out = (input_mode_out == `ACD_RST_FIELD2);

// Spread switching follows spread_spectrum_enable_out directly
// Cross select in route bit 4 swaps channels; mixing is analogue

endmodule // acd_control_decoder

// File: dv/acd_control_decoder_assertions.sv
`timescale 1ns/100ps
module acd_checker (
    input wire logic       clock_in,
    input wire logic       reset_n_in,
    input wire logic       scl_in,
    input wire logic       ctrl_reset_n_in,
    input wire logic       sda_out,
    input wire logic       sda_oe_out,
    input wire logic       word_strobe_out,
    input wire logic       shutdown_out,
    input wire logic       power_on_bit_out,
    input wire logic       stereo_mute_out,
    input wire logic [4:0] speaker_route_out,
    input wire logic [4:0] output_enables_out,
    input wire logic [4:0] right_gain_code_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);
////////////////////////////////////////////////////////////////////////////
    pull_only_a: assert property (sda_oe_out |-> !sda_out)
        else $error("device drove data high");
    shutdown_flag_a: assert property (shutdown_out == !power_on_bit_out)
        else $error("shutdown flag disagrees with power bit");
    pin_clear_a: assert property (!ctrl_reset_n_in [*6] |-> !power_on_bit_out)
        else $error("power bit set while reset pin low");
    power_write_a: assert property ($rose(power_on_bit_out) |-> $past(word_strobe_out))
        else $error("power bit rose without a word");
    field_hold_a: assert property (($changed(speaker_route_out)
        || $changed(output_enables_out) || $changed(right_gain_code_out)
        || $changed(stereo_mute_out)) |-> $past(word_strobe_out))
        else $error("field changed without a word");
    ack_edge_a: assert property ($changed(sda_oe_out) |-> !scl_in)
        else $error("ack moved while clock high");
    ack_hold_a: assert property ($rose(sda_oe_out) |-> ##[1:300] (scl_in && sda_oe_out))
        else $error("ack not held through clock high");
    ack_drop_a: assert property ($rose(sda_oe_out) |-> ##[1:600] !sda_oe_out)
        else $error("ack never released");
    word_ack_a: assert property (word_strobe_out |-> $rose(sda_oe_out))
        else $error("word taken without ack");
    strobe_pulse_a: assert property (word_strobe_out |=> !word_strobe_out)
        else $error("word strobe longer than one cycle");
endmodule // acd_checker

bind acd_control_decoder acd_checker i_chk (.clock_in, .reset_n_in, .scl_in,
    .ctrl_reset_n_in, .sda_out, .sda_oe_out, .word_strobe_out, .shutdown_out,
    .power_on_bit_out, .stereo_mute_out, .speaker_route_out,
    .output_enables_out, .right_gain_code_out);

// File: dv/acd_i2c_master.sv
`timescale 1ns/100ps
module acd_i2c_master #(
    parameter int half_cycles = 126 // Just under 400 kHz at 10 ns
) (
    input  wire logic clock_in,
    input  wire logic sda_wire_in,
    output logic      scl_out,
    output logic      sda_low_out
);
    // Only this model drives the clock; data is open drain
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
    endtask

    task automatic start_bit();
        sda_low_out <= 1'b0;
        scl_out <= 1'b1;
        tick(half_cycles / 2);
        sda_low_out <= 1'b1;
        tick(half_cycles / 2);
        scl_out <= 1'b0;
        tick(half_cycles / 2);
    endtask

    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_low_out <= ~b[i];
            tick(half_cycles / 2);
            scl_out <= 1'b1;
            tick(half_cycles);
            scl_out <= 1'b0;
            tick(half_cycles / 2);
        end
        sda_low_out <= 1'b0;
        tick(half_cycles / 2);
        scl_out <= 1'b1;
        tick(half_cycles / 2);
        ack = ~sda_wire_in;
        tick(half_cycles / 2);
        scl_out <= 1'b0;
        tick(half_cycles / 2);
    endtask

    task automatic stop_bit();
        sda_low_out <= 1'b1;
        tick(half_cycles / 2);
        scl_out <= 1'b1;
        tick(half_cycles / 2);
        sda_low_out <= 1'b0;
        tick(half_cycles / 2);
    endtask
endmodule // acd_i2c_master

// File: dv/tb_acd_control_decoder.sv
`timescale 1ns/100ps
module tb_acd_control_decoder;
    typedef struct packed {
        logic [7:0] w;
        logic [4:0] e;
    } acd_row_t;
    logic       clock_in, reset_n_in, addr_select_in, ctrl_reset_n_in;
    wire        scl, sda_low, sda, sda_o, sda_oe, pw, sh, dm;
    wire  [2:0] st, sk, ep, sp, hg;
    wire  [1:0] md, sg, rg;
    wire  [4:0] ob [14];
    int         n_checks = 0;
    int         miscompares = 0;
    acd_row_t   rows [14] = '{
        '{8'h01, 5'h01}, '{8'h0D, 5'h05},
        '{8'h36, 5'h06}, '{8'h3B, 5'h03},
        '{8'h56, 5'h16}, '{8'h69, 5'h09},
        '{8'h9B, 5'h1B}, '{8'hBF, 5'h1F},
        '{8'hC1, 5'h01}, '{8'hF0, 5'h10},
        '{8'h15, 5'h05}, '{8'h1A, 5'h02},
        '{8'h23, 5'h03}, '{8'h2E, 5'h06}};

    // Open-drain wire with pull-up
    assign sda = (sda_oe ? sda_o : 1'b1) & ~sda_low;
    assign ob[0] = {4'h0, pw};
    assign ob[1] = {2'h0, st};
    assign ob[2] = {2'h0, sk};
    assign ob[3] = {2'h0, ep};
    assign ob[10] = {2'h0, sp};
    assign ob[11] = {3'h0, sg};
    assign ob[12] = {3'h0, rg};
    assign ob[13] = {2'h0, hg};

    acd_control_decoder i_dut (
        .clock_in(clock_in), .reset_n_in(reset_n_in), .scl_in(scl),
        .sda_in(sda), .addr_select_in(addr_select_in),
        .ctrl_reset_n_in(ctrl_reset_n_in), .sda_out(sda_o),
        .sda_oe_out(sda_oe), .word_strobe_out(), .shutdown_out(sh),
        .power_on_bit_out(pw), .stereo_mute_out(st[2]),
        .first_pair_input_select_out(st[1]),
        .second_pair_input_select_out(st[0]), .differential_input_out(dm),
        .input_mode_out(md), .spatial_narrow_select_out(sp[2]),
        .spatial_on_speaker_out(sp[1]), .spatial_on_headphone_out(sp[0]),
        .spatial_gain_out(sg), .regulator_high_select_out(rg[1]),
        .turn_on_fast_out(rg[0]), .headphone_gain_out(hg),
        .spread_spectrum_enable_out(sk[2]),
        .right_speaker_gain_select_out(sk[1]),
        .left_speaker_gain_select_out(sk[0]),
        .earpiece_gain_select_out(ep[2]), .earpiece_mono_select_out(ep[1]),
        .earpiece_stereo_select_out(ep[0]), .speaker_route_out(ob[4]),
        .headphone_route_out(ob[5]), .output_enables_out(ob[6]),
        .mono_gain_code_out(ob[7]), .left_gain_code_out(ob[8]),
        .right_gain_code_out(ob[9])
    );
    acd_i2c_master i_m (
        .clock_in(clock_in), .sda_wire_in(sda), .scl_out(scl),
        .sda_low_out(sda_low)
    );

    always #5 clock_in = ~clock_in;
////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [4:0] seen, input logic [4:0] want);
        n_checks++;
        if (seen !== want) begin
            miscompares++;
            $display("CHECK FAILED %0t seen %h want %h", $time, seen, want);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // A third byte, when asked for, must go unanswered
    task automatic xfer(input logic [7:0] a, d, input logic ea, ed, x3);
        logic k;
        i_m.start_bit();
        i_m.send_byte(a, k);
        check({4'h0, k}, {4'h0, ea});
        i_m.send_byte(d, k);
        check({4'h0, k}, {4'h0, ed});
        if (x3) begin
            i_m.send_byte(8'h00, k);
            check({4'h0, k}, 5'h00);
        end
        i_m.stop_bit();
    endtask

    initial begin
        repeat (100000) @(posedge clock_in);
        miscompares++;
        tally_and_finish();
    end

    initial begin
        clock_in = 1'b0;
        reset_n_in = 1'b0;
        addr_select_in = 1'b0;
        ctrl_reset_n_in = 1'b1;
        repeat (5) @(posedge clock_in);
        for (int s = 0; s < 14; s++)
            check(ob[s], 5'h00);
        check({4'h0, sh}, 5'h01);
        check({2'h0, dm, md}, 5'h04);
        reset_n_in <= 1'b1;
        repeat (8) @(posedge clock_in);
        for (int i = 0; i < 14; i++) begin
            xfer(8'hF8, rows[i].w, 1'b1, 1'b1, 1'b0);
            for (int j = 0; j < 14; j++)
                check(ob[j], j <= i ? rows[j].e : 5'h00);
        end
        check({2'h0, dm, md}, 5'h01);
        // Foreign address, read bit, then the other select level
        xfer(8'hFA, 8'h00, 1'b0, 1'b0, 1'b0);
        xfer(8'hF9, 8'h00, 1'b0, 1'b0, 1'b0);
        addr_select_in <= 1'b1;
        xfer(8'hF8, 8'h00, 1'b0, 1'b0, 1'b0);
        check({4'h0, pw}, 5'h01);
        xfer(8'hFA, 8'hF5, 1'b1, 1'b1, 1'b1);
        check(ob[9], 5'h15);
        check({4'h0, pw}, 5'h01);
        ctrl_reset_n_in <= 1'b0;
        repeat (10) @(posedge clock_in);
        check({3'h0, pw, sh}, 5'h01);
        check(ob[7], 5'h1F);
        ctrl_reset_n_in <= 1'b1;
        repeat (20) @(posedge clock_in);
        check({4'h0, pw}, 5'h00);
        xfer(8'hFA, 8'h01, 1'b1, 1'b1, 1'b0);
        check({3'h0, pw, sh}, 5'h02);
        // Mid-run reset clears every register again
        reset_n_in <= 1'b0;
        repeat (3) @(posedge clock_in);
        for (int s = 0; s < 14; s++)
            check(ob[s], 5'h00);
        check({4'h0, sh}, 5'h01);
        tally_and_finish();
    end
endmodule // tb_acd_control_decoder
